// ===== core/irq_ctrl_pkg.sv
// Shared constants, field layouts and carrier types for the interrupt controller.
// Assumes a single system clock; every rate below it is a machine-cycle enable.
package irq_ctrl_pkg;

	// Source count, level count and priority groups
	localparam int NUM_SOURCES = 10;
	localparam int NUM_LEVELS  = 4;
	localparam int NUM_GROUPS  = 6;

	// Register indices as printed; the AXI byte address is four times the index
	localparam logic [7:0] IDX_ENABLE_PRIMARY     = 8'hA8;
	localparam logic [7:0] IDX_PRIORITY_LOW_BITS  = 8'hA9;
	localparam logic [7:0] IDX_ENABLE_SECONDARY   = 8'hB8;
	localparam logic [7:0] IDX_PRIORITY_HIGH_BITS = 8'hB9;
	localparam logic [7:0] IDX_REQUEST_FLAGS      = 8'hC0;
	localparam logic [7:0] IDX_SERVICE_STATUS     = 8'hC8;
	localparam int         ADDR_W                 = 12;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE_PRIMARY     = {2'h0, IDX_ENABLE_PRIMARY, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_PRIORITY_LOW_BITS  = {2'h0, IDX_PRIORITY_LOW_BITS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_ENABLE_SECONDARY   = {2'h0, IDX_ENABLE_SECONDARY, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_PRIORITY_HIGH_BITS = {2'h0, IDX_PRIORITY_HIGH_BITS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_REQUEST_FLAGS      = {2'h0, IDX_REQUEST_FLAGS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_SERVICE_STATUS     = {2'h0, IDX_SERVICE_STATUS, 2'h0};

	// Reset values and writable masks
	localparam logic [7:0] RESET_VALUE    = 8'h00;
	localparam logic [7:0] PRIORITY_MASK  = 8'h3F;
	localparam logic [7:0] ENABLE0_MASK   = 8'hBF;
	localparam logic [7:0] ENABLE1_MASK   = 8'hB3;
	localparam logic [7:0] REQUEST_MASK   = 8'hF3;

	// Enable register 0 fields
	localparam int EN0_GLOBAL_IRQ_GATE = 7;
	localparam int EN0_TIMER2          = 5;
	localparam int EN0_SERIAL0         = 4;
	localparam int EN0_TIMER1          = 3;
	localparam int EN0_EXT_PIN1        = 2;
	localparam int EN0_TIMER0          = 1;
	localparam int EN0_EXT_PIN0        = 0;

	// Enable register 1 fields
	localparam int EN1_TIMER2_RELOAD   = 7;
	localparam int EN1_TWO_WIRE        = 5;
	localparam int EN1_LOW_VOLTAGE     = 4;
	localparam int EN1_SERIAL_PERIPH   = 1;
	localparam int EN1_PULSE_WIDTH     = 0;

	// Request register fields
	localparam int REQ_TIMER2_RELOAD   = 7;
	localparam int REQ_TIMER2_OVERFLOW = 6;
	localparam int REQ_TWO_WIRE        = 5;
	localparam int REQ_LOW_VOLTAGE     = 4;
	localparam int REQ_SERIAL_PERIPH   = 1;
	localparam int REQ_PULSE_WIDTH     = 0;

	// Status register fields
	localparam int STAT_IN_SERVICE_LSB = 0;
	localparam int STAT_FORCED_CALL    = 4;

	// Source indices, in polling order (lowest index polled first)
	localparam int SRC_EXT_PIN0     = 0;
	localparam int SRC_PULSE_WIDTH  = 1;
	localparam int SRC_TIMER0       = 2;
	localparam int SRC_SERIAL_PERIPH = 3;
	localparam int SRC_EXT_PIN1     = 4;
	localparam int SRC_TIMER1       = 5;
	localparam int SRC_SERIAL0      = 6;
	localparam int SRC_LOW_VOLTAGE  = 7;
	localparam int SRC_TIMER2       = 8;
	localparam int SRC_TWO_WIRE     = 9;

	// Vector address of each source, indexed as above
	localparam logic [15:0] VECTOR_ADDR [NUM_SOURCES] = '{
		16'h0003, 16'h0043, 16'h000B, 16'h004B, 16'h0013,
		16'h001B, 16'h0023, 16'h0063, 16'h002B, 16'h006B};

	// Priority group of each source, indexed as above
	localparam logic [2:0] SOURCE_GROUP [NUM_SOURCES] = '{
		3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};

	// Latency in machine cycles
	localparam int DETECT_CYCLES = 1;
	localparam int CALL_CYCLES   = 6;
	localparam int MIN_LATENCY   = DETECT_CYCLES + CALL_CYCLES;
	localparam int MACHINE_DIV_DEFAULT = 12;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Request levels held inside other peripherals
	typedef struct packed {
		logic serial0_rx_tx_flags;
		logic timer1_overflow_flag;
		logic ext_pin1_req_flag;
		logic timer0_overflow_flag;
		logic ext_pin0_req_flag;
	} periph_level_type;

	// One-cycle set events for the flags held here
	typedef struct packed {
		logic timer2_reload_flag;
		logic timer2_overflow_flag;
		logic two_wire_req_flag;
		logic low_voltage_req_flag;
		logic serial_periph_req_flag;
		logic pulse_width_req_flag;
	} flag_set_type;

	// Forced call toward the sequencer
	typedef struct packed {
		logic        forced_call;
		logic [15:0] vector;
	} call_type;

	typedef enum logic [0:0] {
		CALL_IDLE = 1'b0,
		CALL_RUN  = 1'b1
	} call_state_type;

endpackage

// ===== core/priority_poll.sv
// Sampling and polling stage: picks the winning request once per machine cycle.
// Assumes requests are already masked and synchronous to aclk.
`timescale 1ns/1ps
module priority_poll
	import irq_ctrl_pkg::*;
#(
	parameter int N = NUM_SOURCES
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 sample,
	input  wire logic [N-1:0]         req,
	input  wire logic [N-1:0][1:0]    level,
	output      logic                 win_valid,
	output      logic [3:0]           win_source,
	output      logic [1:0]           win_level
);

	typedef struct packed {
		logic       valid;
		logic [3:0] source;
		logic [1:0] level;
	} poll_state_type;

	poll_state_type state;
	poll_state_type next_state;
	logic [NUM_LEVELS-1:0][N-1:0] hit;

	if (N < 1 || N > 16) begin : g_check
		$error("priority_poll: N out of range");
	end

	// One hit line per source and level
	for (genvar s = 0; s < N; s++) begin : g_src
		for (genvar l = 0; l < NUM_LEVELS; l++) begin : g_lvl
			assign hit[l][s] = req[s] && (level[s] == 2'(l));
		end
	end

	// Highest level first, then fixed polling order; captured only on the machine tick
	always_comb begin
		logic found;
		found = 1'b0;
		next_state = state;
		if (sample) begin
			next_state.valid = 1'b0;
			for (int l = NUM_LEVELS - 1; l >= 0; l--) begin
				for (int s = 0; s < N; s++) begin
					if (!found && hit[l][s]) begin
						found = 1'b1;
						next_state.valid  = 1'b1; // RULE7
						next_state.source = 4'(s); // RULE22
						next_state.level  = 2'(l); // RULE1
					end
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign win_valid  = state.valid;
	assign win_source = state.source;
	assign win_level  = state.level;

endmodule // priority_poll

// ===== core/prioritized_interrupt_controller.sv
// Interrupt controller: request flags, enables, four-level priority, forced call and nesting.
// Assumes an AXI4-Lite master, a sequencer that marks instruction boundaries and
// return-from-interrupt, and peripherals that drive request levels or set pulses on aclk.
`timescale 1ns/1ps

// Operation
// RULE1: Ten sources, four priority levels
// RULE2: Per-source enable masks each request
// RULE3: Only strictly higher level preempts service
// RULE4: Equal or lower level waits for return
// RULE5: Return ends the current service level
// RULE6: Flags set regardless of enables
// RULE7: Sample flags once per machine cycle
// RULE8: Pending enabled request forces long call
// RULE9: Minimum latency seven machine cycles
// RULE10: Ext0 0003H, timer0 000BH, ext1 0013H
// RULE11: Timer1 001BH, serial 0023H, timer2 002BH
// RULE12: PWM 0043H, SPI 004BH
// RULE13: Low voltage 0063H, IIC 006BH
// RULE14: Enable register 0 layout, resets zero
// RULE15: Enable register 1 layout
// RULE16: Timer2 reload flag cleared only by software
// RULE17: Timer2 overflow flag cleared only by software
// RULE18: PWM flag cleared only by software
// RULE19: IIC, LOW_VOLTAGE_DETECT, SPI flags cleared by writing zero
// RULE20: Sources paired into six priority groups
// RULE21: Level from high and low priority bits
// RULE22: Fixed polling order within a level
module prioritized_interrupt_controller
	import irq_ctrl_pkg::*;
#(
	parameter int MACHINE_DIV = MACHINE_DIV_DEFAULT
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output      logic                  s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output      logic                  s_axi_wready,
	output      logic [1:0]            s_axi_bresp,
	output      logic                  s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output      logic                  s_axi_arready,
	output      logic [31:0]           s_axi_rdata,
	output      logic [1:0]            s_axi_rresp,
	output      logic                  s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire periph_level_type      periph_level,
	input  wire flag_set_type          flag_set,
	input  wire logic                  instr_boundary,
	input  wire logic                  reti_done,
	output      call_type              call,
	output      logic [NUM_SOURCES-1:0] vector_ack,
	output      logic                  machine_tick
);

	localparam int TICK_W = 8;

	typedef struct packed {
		logic [7:0]             enable_primary;
		logic [7:0]             enable_secondary;
		logic [7:0]             priority_low;
		logic [7:0]             priority_high;
		logic [7:0]             request;
		logic [TICK_W-1:0]      tick_count;
		logic                   tick;
		call_state_type         call_state;
		logic [2:0]             call_count;
		logic [NUM_LEVELS-1:0]  in_service;
		logic                   forced_call;
		logic [15:0]            call_vector;
		logic [NUM_SOURCES-1:0] ack;
		logic                   aw_held;
		logic [ADDR_W-1:0]      aw_addr;
		logic                   w_held;
		logic [31:0]            w_data;
		logic [3:0]             w_strb;
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} ctrl_state_type;

	ctrl_state_type state;
	ctrl_state_type next_state;

	logic [NUM_SOURCES-1:0]      raw_req;
	logic [NUM_SOURCES-1:0]      src_enable;
	logic [NUM_SOURCES-1:0]      masked_req;
	logic [NUM_SOURCES-1:0][1:0] src_level;
	logic                        win_valid;
	logic [3:0]                  win_source;
	logic [1:0]                  win_level;

	if (MACHINE_DIV < 1 || MACHINE_DIV > 2 ** TICK_W) begin : g_check
		$error("prioritized_interrupt_controller: MACHINE_DIV out of range");
	end

	// Raw requests in polling order; flags count whatever the enables say, except the timer2 reload flag
	assign raw_req[SRC_EXT_PIN0]      = periph_level.ext_pin0_req_flag; // RULE6
	assign raw_req[SRC_PULSE_WIDTH]   = state.request[REQ_PULSE_WIDTH];
	assign raw_req[SRC_TIMER0]        = periph_level.timer0_overflow_flag;
	assign raw_req[SRC_SERIAL_PERIPH] = state.request[REQ_SERIAL_PERIPH];
	assign raw_req[SRC_EXT_PIN1]      = periph_level.ext_pin1_req_flag;
	assign raw_req[SRC_TIMER1]        = periph_level.timer1_overflow_flag;
	assign raw_req[SRC_SERIAL0]       = periph_level.serial0_rx_tx_flags;
	assign raw_req[SRC_LOW_VOLTAGE]   = state.request[REQ_LOW_VOLTAGE];
	// Reload flag only counts while its own extra enable is set
	assign raw_req[SRC_TIMER2]        = state.request[REQ_TIMER2_OVERFLOW]
		| (state.request[REQ_TIMER2_RELOAD] & state.enable_secondary[EN1_TIMER2_RELOAD]); // RULE15
	assign raw_req[SRC_TWO_WIRE]      = state.request[REQ_TWO_WIRE];

	// Per-source enables
	assign src_enable[SRC_EXT_PIN0]      = state.enable_primary[EN0_EXT_PIN0]; // RULE14
	assign src_enable[SRC_PULSE_WIDTH]   = state.enable_secondary[EN1_PULSE_WIDTH]; // RULE15
	assign src_enable[SRC_TIMER0]        = state.enable_primary[EN0_TIMER0];
	assign src_enable[SRC_SERIAL_PERIPH] = state.enable_secondary[EN1_SERIAL_PERIPH];
	assign src_enable[SRC_EXT_PIN1]      = state.enable_primary[EN0_EXT_PIN1];
	assign src_enable[SRC_TIMER1]        = state.enable_primary[EN0_TIMER1];
	assign src_enable[SRC_SERIAL0]       = state.enable_primary[EN0_SERIAL0];
	assign src_enable[SRC_LOW_VOLTAGE]   = state.enable_secondary[EN1_LOW_VOLTAGE];
	assign src_enable[SRC_TIMER2]        = state.enable_primary[EN0_TIMER2];
	assign src_enable[SRC_TWO_WIRE]      = state.enable_secondary[EN1_TWO_WIRE];

	// Global gate blocks everything, then each source has its own mask
	assign masked_req = raw_req & src_enable
		& {NUM_SOURCES{state.enable_primary[EN0_GLOBAL_IRQ_GATE]}}; // RULE2

	// Level per source from its group's bit in both priority registers
	for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_level
		assign src_level[s] = {state.priority_high[SOURCE_GROUP[s]],
			state.priority_low[SOURCE_GROUP[s]]}; // RULE20 RULE21
	end

	// Detection stage: one machine cycle of sampling and polling
	priority_poll #(
		.N          (NUM_SOURCES)
	) poll (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.sample     (state.tick),
		.req        (masked_req),
		.level      (src_level),
		.win_valid  (win_valid),
		.win_source (win_source),
		.win_level  (win_level)
	);

	// Next-state logic: divider, register file, call sequencing and AXI slave
	always_comb begin
		logic [7:0]            wr_byte;
		logic                  do_write;
		logic                  preempt_ok;
		logic [NUM_LEVELS-1:0] at_or_above;
		wr_byte     = 8'h00;
		do_write    = 1'b0;
		preempt_ok  = 1'b0;
		at_or_above = '0;
		next_state  = state;

		// Machine-cycle enable from the system clock
		next_state.tick = 1'b0;
		if (state.tick_count == TICK_W'(MACHINE_DIV - 1)) begin
			next_state.tick_count = '0;
			next_state.tick       = 1'b1;
		end else begin
			next_state.tick_count = state.tick_count + TICK_W'(1);
		end

		// Write channel capture in either order
		if (s_axi_awvalid && state.awready) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && state.wready) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
		end

		// Perform the write once both halves are in and the last response is gone
		if (state.aw_held && state.w_held && !state.bvalid) begin
			do_write           = state.w_strb[0];
			wr_byte            = state.w_data[7:0];
			next_state.aw_held = 1'b0;
			next_state.w_held  = 1'b0;
			next_state.bvalid  = 1'b1;
			next_state.bresp   = RESP_OKAY;
			unique case (state.aw_addr)
				ADDR_ENABLE_PRIMARY: begin
					if (do_write) next_state.enable_primary = wr_byte & ENABLE0_MASK; // RULE14
				end
				ADDR_ENABLE_SECONDARY: begin
					if (do_write) next_state.enable_secondary = wr_byte & ENABLE1_MASK; // RULE15
				end
				ADDR_PRIORITY_LOW_BITS: begin
					if (do_write) next_state.priority_low = wr_byte & PRIORITY_MASK; // RULE21
				end
				ADDR_PRIORITY_HIGH_BITS: begin
					if (do_write) next_state.priority_high = wr_byte & PRIORITY_MASK;
				end
				ADDR_REQUEST_FLAGS: begin
					// Software may clear or set flags; hardware never clears them
					if (do_write) next_state.request = wr_byte & REQUEST_MASK; // RULE16 RULE17 RULE18 RULE19
				end
				ADDR_SERVICE_STATUS: begin
					next_state.bresp = RESP_OKAY; // Read-only, writes are ignored
				end
				default: begin
					next_state.bresp = RESP_SLVERR;
				end
			endcase
		end
		next_state.awready = !next_state.aw_held;
		next_state.wready  = !next_state.w_held;

		// Hardware set applied last so it wins over a clear in the same cycle
		next_state.request[REQ_TIMER2_RELOAD]   = next_state.request[REQ_TIMER2_RELOAD]
			| flag_set.timer2_reload_flag; // RULE6 RULE16
		next_state.request[REQ_TIMER2_OVERFLOW] = next_state.request[REQ_TIMER2_OVERFLOW]
			| flag_set.timer2_overflow_flag; // RULE17
		next_state.request[REQ_TWO_WIRE]        = next_state.request[REQ_TWO_WIRE]
			| flag_set.two_wire_req_flag; // RULE19
		next_state.request[REQ_LOW_VOLTAGE]     = next_state.request[REQ_LOW_VOLTAGE]
			| flag_set.low_voltage_req_flag;
		next_state.request[REQ_SERIAL_PERIPH]   = next_state.request[REQ_SERIAL_PERIPH]
			| flag_set.serial_periph_req_flag;
		next_state.request[REQ_PULSE_WIDTH]     = next_state.request[REQ_PULSE_WIDTH]
			| flag_set.pulse_width_req_flag; // RULE18

		// Read channel: one word per request, answered on the next edge
		if (state.rvalid && s_axi_rready) begin
			next_state.rvalid = 1'b0;
		end
		if (s_axi_arvalid && state.arready) begin
			next_state.rvalid = 1'b1;
			next_state.rresp  = RESP_OKAY;
			next_state.rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				ADDR_ENABLE_PRIMARY:     next_state.rdata[7:0] = state.enable_primary;
				ADDR_ENABLE_SECONDARY:   next_state.rdata[7:0] = state.enable_secondary;
				ADDR_PRIORITY_LOW_BITS:  next_state.rdata[7:0] = state.priority_low;
				ADDR_PRIORITY_HIGH_BITS: next_state.rdata[7:0] = state.priority_high;
				ADDR_REQUEST_FLAGS:      next_state.rdata[7:0] = state.request;
				ADDR_SERVICE_STATUS: begin
					next_state.rdata[STAT_IN_SERVICE_LSB +: NUM_LEVELS] = state.in_service;
					next_state.rdata[STAT_FORCED_CALL]                  = state.forced_call;
				end
				default:                 next_state.rresp = RESP_SLVERR;
			endcase
		end
		next_state.arready = !next_state.rvalid;

		// A new call is allowed only if no level at or above the winner is in service
		for (int l = 0; l < NUM_LEVELS; l++) begin
			at_or_above[l] = (l >= int'(win_level));
		end
		preempt_ok = ((state.in_service & at_or_above) == '0); // RULE3 RULE4

		// Return from interrupt releases the highest level in service
		if (reti_done) begin
			for (int l = 0; l < NUM_LEVELS; l++) begin
				if (state.in_service[l] && ((state.in_service >> (l + 1)) == '0)) begin
					next_state.in_service[l] = 1'b0; // RULE5
				end
			end
		end

		// Forced long call: started at an instruction boundary, lasts six machine cycles
		next_state.ack = '0;
		unique case (state.call_state)
			CALL_IDLE: begin
				if (state.tick && win_valid && instr_boundary && preempt_ok) begin
					next_state.call_state  = CALL_RUN; // RULE8
					next_state.call_count  = 3'(CALL_CYCLES - 1); // RULE9
					next_state.forced_call = 1'b1;
					next_state.call_vector = VECTOR_ADDR[win_source]; // RULE10 RULE11 RULE12 RULE13
					next_state.ack[win_source] = 1'b1;
					next_state.in_service[win_level] = 1'b1; // RULE3
				end
			end
			CALL_RUN: begin
				if (state.tick) begin
					if (state.call_count == 3'h0) begin
						next_state.call_state  = CALL_IDLE;
						next_state.forced_call = 1'b0;
					end else begin
						next_state.call_count = state.call_count - 3'h1;
					end
				end
			end
		endcase
	end

	// Single state register; synchronous active-low reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state                  <= '0;
			state.enable_primary   <= RESET_VALUE; // RULE14
			state.enable_secondary <= RESET_VALUE;
			state.priority_low     <= RESET_VALUE;
			state.priority_high    <= RESET_VALUE;
			state.request          <= RESET_VALUE;
			state.call_state       <= CALL_IDLE;
			state.bresp            <= RESP_OKAY;
			state.rresp            <= RESP_OKAY;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from the state register
	assign s_axi_awready    = state.awready;
	assign s_axi_wready     = state.wready;
	assign s_axi_bvalid     = state.bvalid;
	assign s_axi_bresp      = state.bresp;
	assign s_axi_arready    = state.arready;
	assign s_axi_rvalid     = state.rvalid;
	assign s_axi_rdata      = state.rdata;
	assign s_axi_rresp      = state.rresp;
	assign call.forced_call = state.forced_call;
	assign call.vector      = state.call_vector;
	assign vector_ack       = state.ack;
	assign machine_tick     = state.tick;

endmodule // prioritized_interrupt_controller

// ===== verification/seq_model.sv
// Model of the core sequencer: instruction boundaries and return-from-interrupt.
// Assumes the bench commands each return.
`timescale 1ns/1ps
module seq_model
	import irq_ctrl_pkg::*;
(
	input  wire logic     aclk,
	input  wire logic     aresetn,
	input  wire logic     slow,
	input  wire logic     reti_req,
	input  wire call_type call,
	output      logic     instr_boundary,
	output      logic     reti_done
);
	logic phase;
	// No boundary from the clock after a forced call rises until it falls: the call is one long instruction
	always_ff @(posedge aclk) begin
		phase          <= aresetn ? !phase : 1'b0;
		instr_boundary <= aresetn && !call.forced_call && (!slow || phase);
		reti_done      <= aresetn && reti_req;
	end
endmodule // seq_model

// ===== verification/irq_ctrl_asserts.sv
// Port checker: forced call, acknowledge, bus handshakes.
// Assumes it is bound into the controller and sees only its ports.
`timescale 1ns/1ps
module irq_ctrl_asserts
	import irq_ctrl_pkg::*;
(
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_bready,
	input wire logic                   s_axi_arready,
	input wire logic                   s_axi_rvalid,
	input wire logic                   instr_boundary,
	input wire call_type               call,
	input wire logic [NUM_SOURCES-1:0] vector_ack,
	input wire logic                   machine_tick
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [3:0] call_ticks;
	// Machine ticks while the call stands
	always_ff @(posedge aclk) begin
		if (!aresetn || !call.forced_call)
			call_ticks <= 4'h0;
		else if (machine_tick)
			call_ticks <= call_ticks + 4'h1;
	end
	chk_call_length: assert property ($fell(call.forced_call) |-> call_ticks == 4'h6)
		else $error("forced call length wrong");
	chk_ack_at_start: assert property ($rose(call.forced_call) |-> $onehot(vector_ack))
		else $error("call started without one acknowledge");
	chk_ack_pulse: assert property (|vector_ack |-> $rose(call.forced_call) ##1 vector_ack == '0)
		else $error("acknowledge outside call start");
	chk_vector_hold: assert property (call.forced_call && $past(call.forced_call) |-> $stable(call.vector))
		else $error("vector moved during call");
	chk_call_boundary: assert property ($rose(call.forced_call) |-> $past(instr_boundary))
		else $error("call started off a boundary");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data stands");
	// Vector follows the acknowledged source
	for (genvar g = 0; g < NUM_SOURCES; g++) begin : g_vec
		chk_vector_map: assert property (vector_ack[g] |-> call.vector == VECTOR_ADDR[g])
			else $error("vector does not match source");
	end
endmodule // irq_ctrl_asserts

bind prioritized_interrupt_controller irq_ctrl_asserts irq_ctrl_asserts_inst (.aclk,
	.aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .instr_boundary, .call, .vector_ack,
	.machine_tick);

// ===== verification/tb_prioritized_interrupt_controller.sv
// Controller bench: bus tasks, sources, vector checks.
// Assumes a two-clock machine cycle and the sequencer model beside the design.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_prioritized_interrupt_controller;
	import irq_ctrl_pkg::*;
	localparam int DIV = 2;
	// Source index to {held in controller, bit of its stimulus port}
	localparam logic [3:0] SRC_BIT [10] = '{4'h0, 4'h8, 4'h1, 4'h9, 4'h2, 4'h3, 4'h4, 4'hA, 4'hC, 4'hB};
	localparam logic [ADDR_W-1:0] REGS [5] = '{ADDR_ENABLE_PRIMARY, ADDR_PRIORITY_LOW_BITS,
		ADDR_ENABLE_SECONDARY, ADDR_PRIORITY_HIGH_BITS, ADDR_REQUEST_FLAGS};
	logic                   aclk, aresetn, slow, reti_req, instr_boundary, reti_done, machine_tick;
	logic [ADDR_W-1:0]      s_axi_awaddr, s_axi_araddr;
	logic [31:0]            s_axi_wdata, s_axi_rdata;
	logic [3:0]             s_axi_wstrb;
	logic [1:0]             s_axi_bresp, s_axi_rresp, r;
	logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	periph_level_type       periph_level;
	flag_set_type           flag_set;
	call_type               call;
	logic [NUM_SOURCES-1:0] vector_ack;
	logic [15:0]            got_vec;
	logic [7:0]             q;
	int                     miscompares = 0, n_compared = 0, n_calls = 0, i;

	prioritized_interrupt_controller #(.MACHINE_DIV(DIV)) prioritized_interrupt_controller_inst (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_level, .flag_set, .instr_boundary, .reti_done, .call,
		.vector_ack, .machine_tick);
	seq_model seq_model_inst (.aclk, .aresetn, .slow, .reti_req, .call, .instr_boundary, .reti_done);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Log each call start
	always @(posedge aclk) begin
		if (|vector_ack) begin
			n_calls <= n_calls + 1;
			got_vec <= call.vector;
		end
	end

	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One bus access; answers sampled mid-cycle
	task automatic axi(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic pa, pw, pr;
		int n;
		pa = 1'b1;
		pw = w;
		pr = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (n = 0; n < 40 && pr; n++) begin
			@(negedge aclk);
			if (w ? s_axi_awready : s_axi_arready) pa = 1'b0;
			if (s_axi_wready) pw = 1'b0;
			if (w ? s_axi_bvalid : s_axi_rvalid) begin
				pr = 1'b0;
				q = s_axi_rdata[7:0];
				r = w ? s_axi_bresp : s_axi_rresp;
			end
			@(posedge aclk);
			if (!pa) begin
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (!pw) s_axi_wvalid <= 1'b0;
			if (!pr) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
			end
		end
		if (pr) begin
			miscompares++;
			summarize();
		end
	endtask
	task automatic raise(input int s);
		if (SRC_BIT[s][3]) flag_set[SRC_BIT[s][2:0]] <= 1'b1;
		else periph_level[SRC_BIT[s][2:0]] <= 1'b1;
		@(posedge aclk);
		flag_set <= '0;
	endtask
	task automatic expect_call(input logic [15:0] e);
		int n0, n;
		n0 = n_calls;
		for (n = 0; n < 200 && n_calls == n0; n++) @(posedge aclk);
		if (n_calls == n0) begin
			miscompares++;
			summarize();
		end
		`CHK(got_vec, e)
	endtask
	task automatic expect_none();
		int n0;
		n0 = n_calls;
		repeat (40) @(posedge aclk);
		`CHK(n_calls, n0)
	endtask
	// Return after the call has ended
	task automatic ret();
		repeat (6 * DIV + 2) @(posedge aclk);
		reti_req <= 1'b1;
		@(posedge aclk);
		reti_req <= 1'b0;
	endtask

	initial begin
		{aresetn, slow, reti_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, periph_level, flag_set} = '0;
		s_axi_wstrb = 4'hF;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 5; i++) begin
			axi(0, REGS[i], 8'h00);
			`CHK(q, 8'h00)
		end
		axi(0, 12'h004, 8'h00);
		`CHK(r, RESP_SLVERR)
		axi(1, ADDR_ENABLE_PRIMARY, 8'hFF);
		axi(0, ADDR_ENABLE_PRIMARY, 8'h00);
		`CHK(q, 8'hBF)
		// Masked source: flag sets, no call
		raise(1);
		expect_none();
		axi(0, ADDR_REQUEST_FLAGS, 8'h00);
		`CHK(q, 8'h01)
		axi(1, ADDR_REQUEST_FLAGS, 8'h00);
		axi(1, ADDR_ENABLE_SECONDARY, 8'hFF);
		axi(0, ADDR_ENABLE_SECONDARY, 8'h00);
		`CHK(q, 8'hB3)
		// Each source; held flags survive the call
		for (i = 0; i < 10; i++) begin
			raise(i);
			expect_call(VECTOR_ADDR[i]);
			axi(0, ADDR_REQUEST_FLAGS, 8'h00);
			`CHK(q != 8'h00, SRC_BIT[i][3])
			periph_level <= '0;
			axi(1, ADDR_REQUEST_FLAGS, 8'h00);
			ret();
		end
		// Same level: polling order, loser waits; then a higher level preempts
		slow <= 1'b1;
		periph_level <= 5'h04;
		flag_set <= 6'h10;
		@(posedge aclk);
		flag_set <= '0;
		expect_call(16'h0013);
		periph_level <= '0;
		expect_none();
		ret();
		expect_call(16'h002B);
		axi(1, ADDR_PRIORITY_HIGH_BITS, 8'h08);
		raise(5);
		expect_call(16'h001B);
		summarize();
	end
endmodule // tb_prioritized_interrupt_controller
